// ==== sbc_divider.sv ====
// Purpose: medium-speed clock enable generator for the bus masters
// Assumes: free-running counter on the system clock
// Notes:   produces a one-cycle enable every 2**code cycles for codes up to 5; codes 6 and 7 give every 32 cycles
`timescale 1ns/1ps
module sbc_divider #(
  parameter int CNT_W = sbc_pkg::DIV_CNT_W
) (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic [2:0] code,     // divide select
  output logic            tick      // divided clock enable
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] mask;
  logic             next_tick;

  always_comb begin
    mask      = CNT_W'((1 << code) - 1);
    next_cnt  = cnt + CNT_W'(1);
    next_tick = (code == sbc_pkg::DIV_CODE_FULL) || ((cnt & mask) == mask);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // sbc_divider

// ==== sbc_pkg.sv ====
// Purpose: shared constants for the standby and bus clock control block
// Assumes: 8-bit control register reached over a plain strobe port
// Notes:   field positions, reset values and settle counts live here
package sbc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS          = 4'h1;
  localparam logic [7:0] STANDBY_CONTROL_RST  = 8'h00;
  // ==========================================================
  // field positions
  localparam int STANDBY_SELECT_BIT   = 7;
  localparam int SETTLE_HI            = 6;
  localparam int SETTLE_LO            = 4;
  localparam int TRANSFER_FAST_BIT    = 3;
  localparam int DIV_HI               = 2;
  localparam int DIV_LO               = 0;
  // ==========================================================
  // settle wait: 8192 states for code 000, doubling per code
  localparam int unsigned SETTLE_BASE_STATES = 8192;
  localparam int          SETTLE_CNT_W       = 19;
  localparam logic [2:0]  SETTLE_CODE_MAX    = 3'h5;
  // ==========================================================
  // divider codes
  localparam logic [2:0] DIV_CODE_FULL = 3'h0;
  localparam logic [2:0] DIV_CODE_MAX  = 3'h5;
  localparam int         DIV_CNT_W     = 5;
  // ==========================================================
  // power state
  typedef enum logic [1:0] {
    SBC_RUN,
    SBC_SLEEP,
    SBC_STANDBY,
    SBC_SETTLE
  } sbc_state_e;
endpackage

// ==== sbc_settle_timer.sv ====
// Purpose: oscillation settling counter used when leaving software standby
// Assumes: start is a one-cycle pulse when oscillation restarts
// Notes:   done is a one-cycle pulse after the selected state count
`timescale 1ns/1ps
module sbc_settle_timer #(
  parameter int CNT_W = sbc_pkg::SETTLE_CNT_W
) (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic       start,    // oscillation restart pulse
  input  wire logic [2:0] code,     // settle wait select
  output logic            busy,     // counting
  output logic            done      // settle complete pulse
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] target;
  logic             next_busy;
  logic             next_done;

  always_comb begin
    target    = CNT_W'(sbc_pkg::SETTLE_BASE_STATES << code) - CNT_W'(1);
    next_cnt  = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_cnt  = '0;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt == target) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule // sbc_settle_timer

// ==== sbc_standby_clock_ctrl.sv ====
// Purpose: standby control register, power state and bus-master clock select
// Assumes: sleep_exec, wake_irq, osc_restart are one-cycle pulses from the core
// Notes:   prohibited codes are left to software; hardware clamps them safely
// Summary of operation
// R1: sleep instruction enters sleep if standby_select is 0, software standby if 1.
// R2: interrupts leaving power-down never change standby_select.
// R3: settle wait 8192 states for 000, doubling up to 262144 for 101.
// R4: software picks a settle wait of at least 8 ms with a crystal.
// R5: software picks a settle wait of at least 500 us with external clock.
// R6: medium speed: fast bit 0 all masters slow, 1 transfer master full clock.
// R7: a transfer request switches the transfer clock per the fast bit.
// R8: divide code 000 is full system clock; 100 is one sixteenth.
// R9: software never writes divide codes 110 or 111.
// R10: divide codes 001, 010, 011, 101 give divide by 2, 4, 8, 32.
// R11: register access only while flash register window enable is 0.
// R12: settle counter on system clock releases CPU after selected count.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module sbc_standby_clock_ctrl (
  input  wire logic       sys_clk,             // system clock, 250 MHz
  input  wire logic       rst_b,               // async reset, active low
  input  wire logic [3:0] reg_addr,            // register address
  input  wire logic [7:0] reg_wdata,           // write data
  input  wire logic       reg_wr,              // write strobe
  input  wire logic       reg_rd,              // read strobe
  output logic      [7:0] reg_rdata,           // read data, cycle after strobe
  input  wire logic       flash_window_enable, // flash register window enable
  input  wire logic       sleep_exec,          // sleep instruction pulse
  input  wire logic       wake_irq,            // wake-up interrupt pulse
  input  wire logic       osc_restart,         // oscillator restarted pulse
  input  wire logic       transfer_req,        // transfer controller active
  output logic            sleep_mode,          // in sleep mode
  output logic            standby_mode,        // oscillator stopped
  output logic            settling,            // settle wait running
  output logic            cpu_release,         // cpu and peripherals may run
  output logic            cpu_clk_en,          // cpu clock enable
  output logic            transfer_clk_en      // transfer controller clock enable
);
  sbc_pkg::sbc_state_e state;
  sbc_pkg::sbc_state_e next_state;
  logic [7:0]          standby_control;
  logic [7:0]          next_standby_control;
  logic [7:0]          next_rdata;
  logic                access_ok;
  logic                standby_select;
  logic [2:0]          settle_wait_select;
  logic                transfer_master_fast_clock;
  logic [2:0]          bus_clock_divide_select;
  logic [2:0]          div_code;
  logic [2:0]          settle_code;
  logic                slow_tick;
  logic                settle_busy;
  logic                settle_done;
  logic                settle_start;

  // ==========================================================
  // register file
  assign standby_select             = standby_control[sbc_pkg::STANDBY_SELECT_BIT];
  assign settle_wait_select         = standby_control[sbc_pkg::SETTLE_HI:sbc_pkg::SETTLE_LO];
  assign transfer_master_fast_clock = standby_control[sbc_pkg::TRANSFER_FAST_BIT];
  assign bus_clock_divide_select    = standby_control[sbc_pkg::DIV_HI:sbc_pkg::DIV_LO];
  assign access_ok                  = !flash_window_enable; // see R11

  always_comb begin
    next_standby_control = standby_control; // see R2
    next_rdata           = 8'h00;
    if (reg_wr && access_ok && reg_addr == sbc_pkg::ADDR_STANDBY_CONTROL) begin
      next_standby_control = reg_wdata;
    end
    if (reg_rd && access_ok) begin
      if (reg_addr == sbc_pkg::ADDR_STANDBY_CONTROL) begin
        next_rdata = standby_control;
      end else if (reg_addr == sbc_pkg::ADDR_STATUS) begin
        next_rdata = {4'h0, cpu_release, settling, standby_mode, sleep_mode};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      standby_control <= sbc_pkg::STANDBY_CONTROL_RST;
      reg_rdata       <= 8'h00;
    end else begin
      standby_control <= next_standby_control;
      reg_rdata       <= next_rdata;
    end
  end

  // ==========================================================
  // power state
  always_comb begin
    next_state   = state;
    settle_start = 1'b0;
    case (state)
      sbc_pkg::SBC_RUN: begin
        if (sleep_exec) begin
          next_state = standby_select ? sbc_pkg::SBC_STANDBY : sbc_pkg::SBC_SLEEP; // see R1
        end
      end
      sbc_pkg::SBC_SLEEP: begin
        if (wake_irq) begin
          next_state = sbc_pkg::SBC_RUN;
        end
      end
      sbc_pkg::SBC_STANDBY: begin
        if (osc_restart) begin
          next_state   = sbc_pkg::SBC_SETTLE;
          settle_start = 1'b1; // see R12
        end
      end
      sbc_pkg::SBC_SETTLE: begin
        if (settle_done) begin
          next_state = sbc_pkg::SBC_RUN; // see R12
        end
      end
      default: next_state = sbc_pkg::SBC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sbc_pkg::SBC_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign sleep_mode   = (state == sbc_pkg::SBC_SLEEP);
  assign standby_mode = (state == sbc_pkg::SBC_STANDBY);
  assign settling     = (state == sbc_pkg::SBC_SETTLE);
  assign cpu_release  = (state == sbc_pkg::SBC_RUN);

  // ==========================================================
  // settle timer; prohibited codes 11x clamp to the longest wait
  assign settle_code = (settle_wait_select > sbc_pkg::SETTLE_CODE_MAX) ?
                       sbc_pkg::SETTLE_CODE_MAX : settle_wait_select; // see R3

  sbc_settle_timer sbc_settle_timer_inst (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (settle_start),
    .code    (settle_code),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  // ==========================================================
  // bus master clock; code n divides by 2**n, 11x held at the slowest
  assign div_code = (bus_clock_divide_select > sbc_pkg::DIV_CODE_MAX) ?
                    sbc_pkg::DIV_CODE_MAX : bus_clock_divide_select; // see R8 see R10

  sbc_divider sbc_divider_inst (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .code    (div_code),
    .tick    (slow_tick)
  );

  // transfer master gets the full clock while requesting with the fast bit set, and at divide code 000 always
  assign cpu_clk_en      = cpu_release && slow_tick;
  assign transfer_clk_en = (transfer_req && transfer_master_fast_clock) ? 1'b1 : slow_tick; // see R6 see R7

  // ==========================================================
  // checks
  // length of the current settle wait, kept only for the checks below
  logic [sbc_pkg::SETTLE_CNT_W-1:0] settle_len;
  logic [sbc_pkg::SETTLE_CNT_W-1:0] next_settle_len;

  always_comb begin
    next_settle_len = settling ? (settle_len + sbc_pkg::SETTLE_CNT_W'(1)) : '0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_len <= '0;
    end else begin
      settle_len <= next_settle_len;
    end
  end

  sequence s_standby_entry;
    (state == sbc_pkg::SBC_RUN) && sleep_exec && standby_select;
  endsequence

  sequence s_settle_entry;
    standby_mode && osc_restart;
  endsequence

  a_sleep_entry_mode: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R1
    (state == sbc_pkg::SBC_RUN && sleep_exec) |=>
      (standby_mode == $past(standby_select)) && (sleep_mode != $past(standby_select)))
    else $error("sleep entry went to the wrong mode");

  a_select_kept_wake: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R2
    !(reg_wr && access_ok) |=> $stable(standby_control))
    else $error("control register changed without a write");

  a_access_locked: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R11
    (reg_rd && flash_window_enable) |=> reg_rdata == 8'h00)
    else $error("read while window enabled returned data");

  a_settle_count_min: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R3
    (settle_start && settle_code == 3'h0) |=> settling [*8])
    else $error("settle wait ended too early");

  a_settle_no_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
    settling |-> (settle_busy || settle_done))
    else $error("settling with idle timer");

  a_full_speed_div: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R8
    (div_code == sbc_pkg::DIV_CODE_FULL && $past(div_code) == sbc_pkg::DIV_CODE_FULL)
      |-> slow_tick)
    else $error("full speed clock missing edges");

  a_div_two_gap: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R10
    (div_code == 3'h1 && $past(div_code) == 3'h1 && slow_tick) |=> !slow_tick)
    else $error("divide by two ticked twice in a row");

  a_transfer_fast: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R6
    (transfer_req && transfer_master_fast_clock) |-> transfer_clk_en)
    else $error("transfer master not on full clock");

  // a stable nonzero divide code never gives two ticks in a row unless the fast bit is set
  a_transfer_slow: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R7
    (!transfer_master_fast_clock && div_code != sbc_pkg::DIV_CODE_FULL && $stable(div_code)
      && transfer_clk_en) |=> (!transfer_clk_en || transfer_master_fast_clock))
    else $error("transfer master ticked twice in a row on the medium clock");

  a_standby_holds: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R1
    s_standby_entry |=> (standby_mode && !cpu_release))
    else $error("software standby not entered");

  a_restart_settle: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
    s_settle_entry |=> (settling && !cpu_clk_en))
    else $error("settle wait not started on oscillator restart");

  // the state leaves settle one cycle after the timer's done pulse
  a_settle_length: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R3 see R12
    $fell(settling) |->
      (int'(settle_len) == int'(sbc_pkg::SETTLE_BASE_STATES << settle_code) + 1))
    else $error("settle wait length differs from the selected count");
endmodule // sbc_standby_clock_ctrl

// ==== sbc_standby_clock_ctrl_tb.sv ====
// Purpose: self-checking bench for the standby and bus clock control block
// Assumes: plain strobe register port, single 250 MHz clock, no partner model
// Notes:   table rows cover divide codes; power modes and access refusal follow
`timescale 1ns/1ps
module sbc_standby_clock_ctrl_tb;
  // ==========================================================
  // signals
  logic       sys_clk, rst_b, reg_wr, reg_rd, flash_window_enable;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       sleep_exec, wake_irq, osc_restart, transfer_req;
  logic       sleep_mode, standby_mode, settling, cpu_release, cpu_clk_en, transfer_clk_en;
  int         failures, samples_checked, n_cpu, n_xfer, n;
  logic [7:0] row_w   [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0C, 8'h04, 8'h0C};
  logic       row_t   [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int         row_cpu [9] = '{64, 32, 16, 8, 4, 2, 4, 4, 4};
  int         row_xfr [9] = '{64, 32, 16, 8, 4, 2, 64, 4, 4};

  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

  sbc_standby_clock_ctrl sbc_standby_clock_ctrl_inst (
    .sys_clk             (sys_clk),
    .rst_b               (rst_b),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .flash_window_enable (flash_window_enable),
    .sleep_exec          (sleep_exec),
    .wake_irq            (wake_irq),
    .osc_restart         (osc_restart),
    .transfer_req        (transfer_req),
    .sleep_mode          (sleep_mode),
    .standby_mode        (standby_mode),
    .settling            (settling),
    .cpu_release         (cpu_release),
    .cpu_clk_en          (cpu_clk_en),
    .transfer_clk_en     (transfer_clk_en)
  );

  always #2 sys_clk = ~sys_clk;

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic end_of_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // the whole run needs about 26000 cycles (about 104 us); allow roughly twice that
  initial begin
    #200000;
    failures++;
    end_of_test;
  end

  // ==========================================================
  // main sequence
  initial begin : main
    logic [7:0] d;
    sys_clk = 1'b0; rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; flash_window_enable = 1'b0; sleep_exec = 1'b0; wake_irq = 1'b0;
    osc_restart = 1'b0; transfer_req = 1'b0; failures = 0; samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({cpu_release, sleep_mode, standby_mode, cpu_clk_en, transfer_clk_en, reg_rdata}, 13'h1300)
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, sbc_pkg::STANDBY_CONTROL_RST)
    rd(sbc_pkg::ADDR_STATUS, d); `CHK(d, 8'h08)
    // ==========================================================
    // divide code table, tick counts over 64 cycles
    for (int i = 0; i < 9; i++) begin
      wr(sbc_pkg::ADDR_STANDBY_CONTROL, row_w[i]);
      transfer_req <= row_t[i];
      rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, row_w[i])
      repeat (4) @(posedge sys_clk);
      n_cpu = 0; n_xfer = 0;
      repeat (64) begin
        @(posedge sys_clk);
        #1 if (cpu_clk_en === 1'b1) n_cpu++;
        if (transfer_clk_en === 1'b1) n_xfer++;
      end
      `CHK(n_cpu, row_cpu[i])
      `CHK(n_xfer, row_xfr[i])
    end
    transfer_req <= 1'b0;
    // ==========================================================
    // refused accesses: window enabled, unmapped address
    wr(sbc_pkg::ADDR_STANDBY_CONTROL, 8'h13);
    flash_window_enable <= 1'b1;
    wr(sbc_pkg::ADDR_STANDBY_CONTROL, 8'hFF);
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, 8'h00)
    @(posedge sys_clk) flash_window_enable <= 1'b0;
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, 8'h13)
    wr(4'h9, 8'hAA);
    rd(4'h9, d); `CHK(d, 8'h00)
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, 8'h13)
    // ==========================================================
    // sleep entry and interrupt wake
    wr(sbc_pkg::ADDR_STANDBY_CONTROL, 8'h00);
    @(posedge sys_clk) sleep_exec <= 1'b1;
    @(posedge sys_clk) sleep_exec <= 1'b0;
    #1 `CHK({sleep_mode, standby_mode}, 2'b10)
    rd(sbc_pkg::ADDR_STATUS, d); `CHK(d, 8'h01)
    @(posedge sys_clk) wake_irq <= 1'b1;
    @(posedge sys_clk) wake_irq <= 1'b0;
    #1 `CHK({sleep_mode, cpu_release}, 2'b01)
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, 8'h00)
    // ==========================================================
    // software standby and settle wait for codes 0 and 1
    // short waits only, to keep the run short; firmware sizes the wait from its clock source
    for (int c = 0; c < 2; c++) begin
      wr(sbc_pkg::ADDR_STANDBY_CONTROL, {1'b1, c[2:0], 4'h0});
      @(posedge sys_clk) sleep_exec <= 1'b1;
      @(posedge sys_clk) sleep_exec <= 1'b0;
      #1 `CHK({sleep_mode, standby_mode, cpu_release}, 3'b010)
      @(posedge sys_clk) osc_restart <= 1'b1;
      @(posedge sys_clk) osc_restart <= 1'b0;
      #1 `CHK({settling, cpu_release, cpu_clk_en}, 3'b100)
      n = 1;
      while (settling === 1'b1 && cpu_release !== 1'b1 && n < 40000) begin
        @(posedge sys_clk);
        #1 n++;
      end
      `CHK(n >= (8192 << c) && n <= (8192 << c) + 2, 1'b1)
      `CHK({settling, cpu_release, standby_mode}, 3'b010)
      rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, {1'b1, c[2:0], 4'h0})
    end
    // ==========================================================
    // reset in the middle of a settle wait
    wr(sbc_pkg::ADDR_STANDBY_CONTROL, 8'h80);
    @(posedge sys_clk) sleep_exec <= 1'b1;
    @(posedge sys_clk) sleep_exec <= 1'b0;
    @(posedge sys_clk) osc_restart <= 1'b1;
    @(posedge sys_clk) osc_restart <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 `CHK({settling, standby_mode, cpu_release, reg_rdata}, 11'h100)
    rd(sbc_pkg::ADDR_STANDBY_CONTROL, d); `CHK(d, sbc_pkg::STANDBY_CONTROL_RST)
    end_of_test;
  end
endmodule // sbc_standby_clock_ctrl_tb
